/* core/scpc_defines.svh */
`ifndef SCPC_DEFINES_SVH
`define SCPC_DEFINES_SVH

// ----------------------------------------
// Register offsets on the internal bus
// ----------------------------------------
`define SCPC_OFS_CLK_CTRL0 16'h0006
`define SCPC_OFS_CLK_CTRL1 16'h0007
`define SCPC_OFS_CLK_CTRL3 16'h0009
`define SCPC_OFS_OSC_DET 16'h000c
`define SCPC_OFS_PSC_RST 16'h0028
`define SCPC_OFS_VDET2 16'h0034

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCPC_C0_WAIT_PCS 2
`define SCPC_C0_SUB_STOP 3
`define SCPC_C0_PIN_SW 4
`define SCPC_C0_MAIN_STOP 5
`define SCPC_C0_COARSE 6
`define SCPC_C0_MS_SEL 7
`define SCPC_C1_ALL_STOP 0
`define SCPC_C1_MAIN_FB 1
`define SCPC_C1_SUB_FB 2
`define SCPC_C1_LS_STOP 4
`define SCPC_C1_FINE_LO 6
`define SCPC_C1_FINE_HI 7
`define SCPC_C3_WAIT 0
`define SCPC_C3_WEND_ND 5
`define SCPC_C3_EXIT_LO 6
`define SCPC_C3_EXIT_HI 7
`define SCPC_OD_EN 0
`define SCPC_OD_IRQ_EN 1
`define SCPC_OD_SEL 2
`define SCPC_OD_MON 3
`define SCPC_PR_RST 7
`define SCPC_VD_LOWC 0
`define SCPC_VD_VD0 5
`define SCPC_VD_VD1 6

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SCPC_RST_CLK_CTRL0 8'h28
`define SCPC_RST_CLK_CTRL1 8'h28
`define SCPC_RST_CLK_CTRL3 8'h00
`define SCPC_RST_OSC_DET 8'h04
`define SCPC_RST_VDET2 8'h00
`define SCPC_EXIT_MAIN 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCPC_CLK_PERIOD_NS 10
`define SCPC_DET_DELAY_NS 100000
`define SCPC_DET_DELAY_CYC ((`SCPC_DET_DELAY_NS + `SCPC_CLK_PERIOD_NS - 1) / `SCPC_CLK_PERIOD_NS)

`endif

/* core/scpc_pkg.sv */
package scpc_pkg;

	typedef enum logic [2:0]
	{
		MODE_RUN = 3'b001,
		MODE_WAIT = 3'b010,
		MODE_STOP = 3'b100
	} scpc_mode_e;

	typedef enum logic [1:0]
	{
		SRC_MAIN = 2'h0,
		SRC_SUB = 2'h1,
		SRC_LOCO = 2'h2
	} scpc_src_e;

	typedef struct packed
	{
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scpc_sfr_req_s;

	typedef struct packed
	{
		logic main_run;
		logic sub_run;
		logic loco_run;
		logic main_fb_off;
		logic sub_fb_off;
		logic sub_pins;
	} scpc_osc_ctrl_s;

	typedef struct packed
	{
		logic cpu;
		logic [4:0] periph;
	} scpc_clk_en_s;

endpackage : scpc_pkg

/* core/scpc_sync3.sv */
`timescale 1ns/1ps

module scpc_sync3
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic dout_reg;

	// ----------------------------------------
	// Three stages with agreement filter
	// ----------------------------------------
	// A change is accepted only once the last two stages agree, so a single
	// metastable resolution cannot produce a one-cycle glitch downstream.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			dout_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dout_reg <= (s2_reg == s3_reg) ? s3_reg : dout_reg;
		end
	end

	assign dout = dout_reg;

endmodule : scpc_sync3

/* core/scpc_core.sv */
`timescale 1ns/1ps
`include "scpc_defines.svh"

// Behaviour
// - Main oscillator stop bit halts main crystal at 1, starts it at 0.
// - Sub-clock pin switch can be set to 1 but never cleared by software.
// - Entering stop mode forces the coarse divide bit to 1.
// - CPU clock divide: coarse gives 8, else fine field gives 1, 2, 4, 16.
// - Clock control and detect registers writable only while protect bit 0 is 1.
// - All-clock-stop bit enters stop mode, halts clocks, drops feedback resistors.
// - Low-speed oscillator stop held 0 while on-chip oscillator is system clock.
// - Wait control bit stops CPU clock while oscillators keep running.
// - Wait peripheral stop bit stops divided peripheral clocks in wait mode.
// - Wait ends on reset or interrupt; interrupt exit clears wait bit.
// - Wait entry with no-division bit set clears coarse and fine divide.
// - Exit select 11b clears main stop and system select on mode exit.
// - Clock monitor reports main stop only while detection is enabled.
// - Detected stop with both enables set forces on-chip oscillator selection.
// - Prescaler reset write of 1 clears the prescaler; bit reads 0.
// - Voltage register needs protect bit 3; detector 1 starts after delay.
// - Reset selects undivided on-chip clock with both crystals stopped.
module scpc_core
#(
	parameter int unsigned DET_DELAY_CYC = `SCPC_DET_DELAY_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire scpc_pkg::scpc_sfr_req_s sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic protect_bit_0,
	input wire logic protect_bit_3,
	input wire logic main_osc_halt_raw,
	input wire logic periph_irq,
	output scpc_pkg::scpc_osc_ctrl_s osc_ctrl,
	output scpc_pkg::scpc_src_e sys_clk_src,
	output scpc_pkg::scpc_clk_en_s clk_en,
	output scpc_pkg::scpc_mode_e power_mode,
	output logic osc_stop_irq,
	output logic low_consumption_enable,
	output logic voltage_detect0_enable,
	output logic voltage_detect1_enable,
	output logic voltage_detect1_active
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [4:0] scpc_div_mask(input logic coarse, input logic [1:0] fine);
		logic [4:0] m;
		unique case (fine)
			2'h0: m = 5'h00;
			2'h1: m = 5'h01;
			2'h2: m = 5'h03;
			2'h3: m = 5'h0f;
		endcase
		return coarse ? 5'h07 : m;
	endfunction : scpc_div_mask

	function automatic logic scpc_tick(input logic [4:0] cnt, input logic [4:0] mask);
		return (cnt & mask) == 5'h00;
	endfunction : scpc_tick

	localparam logic [4:0] PERIPH_MASK [5] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1f};
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl0_next;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl1_next;
	logic [7:0] ctrl3_reg;
	logic [7:0] ctrl3_next;
	logic [7:0] osd_reg;
	logic [7:0] osd_next;
	logic [7:0] vdet_reg;
	logic [7:0] vdet_next;
	logic [4:0] presc_reg;
	logic [4:0] presc_next;
	logic [15:0] vd_cnt_reg;
	logic [15:0] vd_cnt_next;
	logic [7:0] rdata_reg;
	scpc_pkg::scpc_mode_e mode_reg;
	scpc_pkg::scpc_mode_e mode_next;
	logic halt_sync;

	scpc_sync3 u_halt_sync
	(
		.clk(clk),
		.rst_n(rst_n),
		.din(main_osc_halt_raw),
		.dout(halt_sync)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [7:0] wd = sfr_req.wdata;
	wire hit_c0 = sfr_req.addr == `SCPC_OFS_CLK_CTRL0;
	wire hit_c1 = sfr_req.addr == `SCPC_OFS_CLK_CTRL1;
	wire hit_c3 = sfr_req.addr == `SCPC_OFS_CLK_CTRL3;
	wire hit_od = sfr_req.addr == `SCPC_OFS_OSC_DET;
	wire hit_pr = sfr_req.addr == `SCPC_OFS_PSC_RST;
	wire hit_vd = sfr_req.addr == `SCPC_OFS_VDET2;
	wire wr_c0 = sfr_req.wr && hit_c0 && protect_bit_0;
	wire wr_c1 = sfr_req.wr && hit_c1 && protect_bit_0;
	wire wr_c3 = sfr_req.wr && hit_c3 && protect_bit_0;
	wire wr_od = sfr_req.wr && hit_od && protect_bit_0;
	wire wr_vd = sfr_req.wr && hit_vd && protect_bit_3;
	wire psc_clear = sfr_req.wr && hit_pr && wd[`SCPC_PR_RST];
	wire in_run = mode_reg == scpc_pkg::MODE_RUN;
	wire in_wait = mode_reg == scpc_pkg::MODE_WAIT;
	wire in_stop = mode_reg == scpc_pkg::MODE_STOP;
	wire enter_stop = in_run && wr_c1 && wd[`SCPC_C1_ALL_STOP];
	wire enter_wait = in_run && !enter_stop && wr_c3 && wd[`SCPC_C3_WAIT];
	wire exit_any = !in_run && periph_irq;
	wire exit_main = ctrl3_reg[`SCPC_C3_EXIT_HI:`SCPC_C3_EXIT_LO] == `SCPC_EXIT_MAIN;
	// monitor valid only with detection enabled
	wire monitor = osd_reg[`SCPC_OD_EN] && halt_sync;
	wire det_both = osd_reg[`SCPC_OD_IRQ_EN] && osd_reg[`SCPC_OD_EN];

	// ----------------------------------------
	// Power mode
	// ----------------------------------------
	always_comb
	begin
		mode_next = mode_reg;
		unique case (mode_reg)
			scpc_pkg::MODE_RUN:
				if (enter_stop || enter_wait)
					mode_next = enter_stop ? scpc_pkg::MODE_STOP : scpc_pkg::MODE_WAIT;
			scpc_pkg::MODE_WAIT, scpc_pkg::MODE_STOP:
				if (periph_irq)
					mode_next = scpc_pkg::MODE_RUN;
		endcase
	end

	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	always_comb
	begin
		ctrl0_next = ctrl0_reg;
		if (wr_c0)
		begin
			ctrl0_next = {wd[7:2], 2'b00};
			ctrl0_next[`SCPC_C0_PIN_SW] = ctrl0_reg[`SCPC_C0_PIN_SW] | wd[`SCPC_C0_PIN_SW];
		end
		if (enter_stop)
			ctrl0_next[`SCPC_C0_COARSE] = 1'b1;
		if (enter_wait && wd[`SCPC_C3_WEND_ND])
			ctrl0_next[`SCPC_C0_COARSE] = 1'b0;
		if (exit_any && exit_main)
			ctrl0_next[`SCPC_C0_MAIN_STOP] = 1'b0;
	end

	always_comb
	begin
		osd_next = osd_reg;
		// clearing the select is refused while stopped
		if (wr_od)
			osd_next = {5'h00, wd[`SCPC_OD_SEL] | monitor, wd[1:0]};
		// return to main crystal on exit
		if (exit_any && exit_main)
			osd_next[`SCPC_OD_SEL] = 1'b0;
		// automatic fallback wins over any clear
		if (monitor && det_both)
			osd_next[`SCPC_OD_SEL] = 1'b1;
	end

	always_comb
	begin
		ctrl1_next = ctrl1_reg;
		if (wr_c1)
			ctrl1_next = {wd[7:1], 1'b0};
		if (enter_wait && wd[`SCPC_C3_WEND_ND])
			ctrl1_next[`SCPC_C1_FINE_HI:`SCPC_C1_FINE_LO] = 2'h0;
		if (osd_next[`SCPC_OD_SEL])
			ctrl1_next[`SCPC_C1_LS_STOP] = 1'b0;
	end

	always_comb
	begin
		ctrl3_next = ctrl3_reg;
		if (wr_c3)
			ctrl3_next = {wd[7:5], 5'h00};
		vdet_next = vdet_reg;
		if (wr_vd)
			vdet_next = {1'b0, wd[6:5], 4'h0, wd[0]};
	end

	// prescaler runs unless cleared or stopped
	assign presc_next = psc_clear ? 5'h00 : (in_stop ? presc_reg : presc_reg + 5'h01);

	// detector 1 enable delay from its rising edge
	assign vd_cnt_next = !vdet_reg[`SCPC_VD_VD1] ? 16'h0000 :
		((vd_cnt_reg == 16'(DET_DELAY_CYC)) ? vd_cnt_reg : vd_cnt_reg + 16'h0001);

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	// Mode bits read from the mode machine so they can never disagree with it.
	wire [7:0] rd_c1 = {ctrl1_reg[7:1], in_stop};
	wire [7:0] rd_c3 = {ctrl3_reg[7:5], 4'h0, in_wait};
	wire [7:0] rd_od = {4'h0, monitor, osd_reg[2:0]};
	wire [7:0] rd_mux = hit_c0 ? ctrl0_reg :
		hit_c1 ? rd_c1 :
		hit_c3 ? rd_c3 :
		hit_od ? rd_od :
		hit_vd ? vdet_reg : 8'h00;
	assign sfr_rdata = rdata_reg;

	// ----------------------------------------
	// State
	// ----------------------------------------
	// reset values select undivided on-chip clock, crystals stopped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl0_reg <= `SCPC_RST_CLK_CTRL0;
			ctrl1_reg <= `SCPC_RST_CLK_CTRL1;
			ctrl3_reg <= `SCPC_RST_CLK_CTRL3;
			osd_reg <= `SCPC_RST_OSC_DET;
			vdet_reg <= `SCPC_RST_VDET2;
			mode_reg <= scpc_pkg::MODE_RUN;
		end
		else
		begin
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			ctrl3_reg <= ctrl3_next;
			osd_reg <= osd_next;
			vdet_reg <= vdet_next;
			mode_reg <= mode_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			presc_reg <= 5'h00;
			vd_cnt_reg <= 16'h0000;
			rdata_reg <= 8'h00;
		end
		else
		begin
			presc_reg <= presc_next;
			vd_cnt_reg <= vd_cnt_next;
			rdata_reg <= sfr_req.rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------
	// Clock and oscillator outputs
	// ----------------------------------------
	wire [4:0] cpu_mask = scpc_div_mask(ctrl0_reg[`SCPC_C0_COARSE], ctrl1_reg[`SCPC_C1_FINE_HI:`SCPC_C1_FINE_LO]);
	// peripheral clocks gated in wait when asked
	wire periph_gate = in_stop || (in_wait && ctrl0_reg[`SCPC_C0_WAIT_PCS]);

	// CPU clock tick from the divided prescaler
	assign clk_en.cpu = in_run && scpc_tick(presc_reg, cpu_mask);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_periph
			assign clk_en.periph[gi] = !periph_gate && scpc_tick(presc_reg, PERIPH_MASK[gi]);
		end
	endgenerate

	// stop mode kills oscillators and feedback resistors
	assign osc_ctrl.main_run = !ctrl0_reg[`SCPC_C0_MAIN_STOP] && !in_stop;
	assign osc_ctrl.sub_run = ctrl0_reg[`SCPC_C0_PIN_SW] && !ctrl0_reg[`SCPC_C0_SUB_STOP] && !in_stop;
	assign osc_ctrl.loco_run = !ctrl1_reg[`SCPC_C1_LS_STOP] && !in_stop;
	assign osc_ctrl.main_fb_off = ctrl1_reg[`SCPC_C1_MAIN_FB] || in_stop;
	assign osc_ctrl.sub_fb_off = ctrl1_reg[`SCPC_C1_SUB_FB] || in_stop;
	assign osc_ctrl.sub_pins = ctrl0_reg[`SCPC_C0_PIN_SW];

	// sub-clock chosen only by software select
	assign sys_clk_src = osd_reg[`SCPC_OD_SEL] ? scpc_pkg::SRC_LOCO :
		(ctrl0_reg[`SCPC_C0_MS_SEL] ? scpc_pkg::SRC_SUB : scpc_pkg::SRC_MAIN);
	assign power_mode = mode_reg;
	assign osc_stop_irq = monitor && osd_reg[`SCPC_OD_IRQ_EN];
	assign low_consumption_enable = vdet_reg[`SCPC_VD_LOWC];
	assign voltage_detect0_enable = vdet_reg[`SCPC_VD_VD0];
	assign voltage_detect1_enable = vdet_reg[`SCPC_VD_VD1];
	assign voltage_detect1_active = vdet_reg[`SCPC_VD_VD1] && (vd_cnt_reg == 16'(DET_DELAY_CYC));

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// main stop follows write
	main_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_c0 && !(exit_any && exit_main) |=> ctrl0_reg[`SCPC_C0_MAIN_STOP] == $past(wd[`SCPC_C0_MAIN_STOP]))
		else $error("main stop bit did not follow write");
	pin_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
		!$fell(ctrl0_reg[`SCPC_C0_PIN_SW])) else $error("pin switch cleared");
	stop_coarse_a: assert property (@(posedge clk) disable iff (!rst_n)
		enter_stop |=> ctrl0_reg[`SCPC_C0_COARSE] && in_stop) else $error("coarse divide not forced on stop");
	div8_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en.cpu && ctrl0_reg[`SCPC_C0_COARSE] |-> presc_reg[2:0] == 3'h0)
		else $error("coarse divide tick misaligned");
	protect_a: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_req.wr && hit_c1 && !protect_bit_0 && in_run |=> in_run && $stable(ctrl1_reg[7:6]))
		else $error("protected register changed");
	stop_osc_a: assert property (@(posedge clk) disable iff (!rst_n)
		in_stop |-> !osc_ctrl.main_run && !osc_ctrl.loco_run && osc_ctrl.main_fb_off && !clk_en.cpu)
		else $error("clock running in stop mode");
	loco_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		osd_reg[`SCPC_OD_SEL] |-> !ctrl1_reg[`SCPC_C1_LS_STOP])
		else $error("low-speed oscillator stopped while selected");
	wait_periph_a: assert property (@(posedge clk) disable iff (!rst_n)
		in_wait && ctrl0_reg[`SCPC_C0_WAIT_PCS] |-> clk_en.periph == 5'h00)
		else $error("peripheral clock ran in wait");
	wait_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
		in_wait && periph_irq |=> in_run && !rd_c3[`SCPC_C3_WAIT]) else $error("wait not left on interrupt");
	wait_nodiv_a: assert property (@(posedge clk) disable iff (!rst_n)
		enter_wait && wd[`SCPC_C3_WEND_ND] |=> cpu_mask == 5'h00) else $error("divider not cleared on wait entry");
	exit_main_a: assert property (@(posedge clk) disable iff (!rst_n)
		exit_any && exit_main |=> !ctrl0_reg[`SCPC_C0_MAIN_STOP]) else $error("main crystal not restarted on exit");
	auto_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		monitor && det_both |=> osd_reg[`SCPC_OD_SEL] && sys_clk_src == scpc_pkg::SRC_LOCO)
		else $error("no fallback to on-chip oscillator");
	// prescaler cleared, then steps to one unless stopped or cleared again
	psc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		psc_clear |=> presc_reg == 5'h00 ##1 presc_reg == 5'h01 || in_stop || psc_clear)
		else $error("prescaler not initialised");
	vd_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(vdet_reg[`SCPC_VD_VD1]) |-> !voltage_detect1_active) else $error("detector 1 active without delay");
	irq_a: assert property (@(posedge clk) disable iff (!rst_n)
		osc_stop_irq |-> osd_reg[`SCPC_OD_EN] && osd_reg[`SCPC_OD_IRQ_EN] && halt_sync)
		else $error("spurious oscillation stop request");

	wait_entry_c: cover property (@(posedge clk) disable iff (!rst_n) enter_wait ##[1:20] in_run);
	stop_entry_c: cover property (@(posedge clk) disable iff (!rst_n) enter_stop ##[1:20] in_run);
	fallback_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(osd_reg[`SCPC_OD_SEL]) && monitor);

endmodule : scpc_core

/* sim/test_system_clock_power_control.sv */
`timescale 1ns/1ps
`include "scpc_defines.svh"

module test_system_clock_power_control;
	localparam logic [15:0] A0 = `SCPC_OFS_CLK_CTRL0;
	localparam logic [15:0] A1 = `SCPC_OFS_CLK_CTRL1;
	localparam logic [15:0] A3 = `SCPC_OFS_CLK_CTRL3;
	localparam logic [15:0] AD = `SCPC_OFS_OSC_DET;
	localparam logic [15:0] AP = `SCPC_OFS_PSC_RST;
	localparam logic [15:0] AV = `SCPC_OFS_VDET2;
	logic clk;
	logic rst_n;
	scpc_pkg::scpc_sfr_req_s sfr_req;
	logic [7:0] sfr_rdata;
	logic protect_bit_0;
	logic protect_bit_3;
	logic main_osc_halt_raw;
	logic periph_irq;
	scpc_pkg::scpc_osc_ctrl_s osc_ctrl;
	scpc_pkg::scpc_src_e sys_clk_src;
	scpc_pkg::scpc_clk_en_s clk_en;
	scpc_pkg::scpc_mode_e power_mode;
	logic osc_stop_irq;
	logic low_consumption_enable;
	logic voltage_detect0_enable;
	logic voltage_detect1_enable;
	logic voltage_detect1_active;
	int num_errors;
	int n_tests;
	int cycles;

	// The short detector delay keeps the enable-delay check to a few cycles.
	scpc_core #(.DET_DELAY_CYC(8)) dut
	(
		.clk(clk),
		.rst_n(rst_n),
		.sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata),
		.protect_bit_0(protect_bit_0),
		.protect_bit_3(protect_bit_3),
		.main_osc_halt_raw(main_osc_halt_raw),
		.periph_irq(periph_irq),
		.osc_ctrl(osc_ctrl),
		.sys_clk_src(sys_clk_src),
		.clk_en(clk_en),
		.power_mode(power_mode),
		.osc_stop_irq(osc_stop_irq),
		.low_consumption_enable(low_consumption_enable),
		.voltage_detect0_enable(voltage_detect0_enable),
		.voltage_detect1_enable(voltage_detect1_enable),
		.voltage_detect1_active(voltage_detect1_active)
	);

	// ----------------------------------------
	// Clock and timeout
	// ----------------------------------------
	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			num_errors = num_errors + 1;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests = n_tests + 1;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			num_errors = num_errors + 1;
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		sfr_req.wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		sfr_req.rd <= 1'b0;
		#1;
		check(name, exp, sfr_rdata);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic pulse_irq();
		@(posedge clk);
		periph_irq <= 1'b1;
		@(posedge clk);
		periph_irq <= 1'b0;
		#1;
	endtask : pulse_irq

	// Counts CPU and f1 ticks over a window, sampled mid-cycle where they are settled.
	task automatic count_en(input int n, output logic [7:0] c, output logic [7:0] f);
		c = 8'h00;
		f = 8'h00;
		repeat (n)
		begin
			@(negedge clk);
			if (clk_en.cpu === 1'b1) c = c + 8'h01;
			if (clk_en.periph[0] === 1'b1) f = f + 8'h01;
		end
	endtask : count_en

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(A0, `SCPC_RST_CLK_CTRL0, "ctrl0");
		rd(A1, `SCPC_RST_CLK_CTRL1, "ctrl1");
		rd(A3, `SCPC_RST_CLK_CTRL3, "ctrl3");
		rd(AD, `SCPC_RST_OSC_DET, "osc_det");
		rd(AP, 8'h00, "psc");
		rd(AV, `SCPC_RST_VDET2, "vdet2");
		rd(16'h0100, 8'h00, "unmapped");
		check("src", {6'h00, scpc_pkg::SRC_LOCO}, {6'h00, sys_clk_src});
		check("osc", 8'h08, {2'h0, osc_ctrl});
		check("mode", 8'h01, {5'h00, power_mode});
	endtask : t_reset

	task automatic t_protect();
		@(posedge clk);
		protect_bit_0 <= 1'b0;
		wr(A0, 8'h08);
		rd(A0, 8'h28, "ctrl0 locked");
		wr(A1, 8'hc1);
		rd(A1, 8'h28, "ctrl1 locked");
		check("mode locked", 8'h01, {5'h00, power_mode});
		@(posedge clk);
		protect_bit_0 <= 1'b1;
		wr(A0, 8'h08);
		rd(A0, 8'h08, "ctrl0 open");
		check("main run", 8'h01, {7'h00, osc_ctrl.main_run});
		wr(AV, 8'h40);
		rd(AV, 8'h00, "vdet locked");
		@(posedge clk);
		protect_bit_3 <= 1'b1;
		wr(AV, 8'h40);
		check("vd1 early", 8'h00, {7'h00, voltage_detect1_active});
		cyc(10);
		check("vd1 late", 8'h01, {7'h00, voltage_detect1_active});
		check("lowc", 8'h00, {7'h00, low_consumption_enable});
	endtask : t_protect

	task automatic t_pins();
		wr(A0, 8'h18);
		check("pins", 8'h01, {7'h00, osc_ctrl.sub_pins});
		wr(A0, 8'h08);
		rd(A0, 8'h18, "pins kept");
	endtask : t_pins

	task automatic t_divide();
		int dv[5] = '{1, 2, 4, 16, 8};
		logic [7:0] c;
		logic [7:0] f;
		for (int i = 0; i < 5; i++)
		begin
			wr(A1, {i[1:0], 6'h28});
			wr(A0, (i == 4) ? 8'h58 : 8'h18);
			count_en(32, c, f);
			check("cpu ticks", 8'(32 / dv[i]), c);
		end
	endtask : t_divide

	task automatic t_prescaler();
		wr(A0, 8'h18);
		wr(A1, 8'he8);
		wr(AP, 8'h80);
		check("cpu at 0", 8'h01, {7'h00, clk_en.cpu});
		check("periph at 0", 8'h1f, {3'h0, clk_en.periph});
		cyc(1);
		check("cpu at 1", 8'h00, {7'h00, clk_en.cpu});
		rd(AP, 8'h00, "psc read");
		wr(A1, 8'h28);
	endtask : t_prescaler

	task automatic t_loco();
		wr(A1, 8'h38);
		rd(A1, 8'h28, "ls stop held");
		check("loco run", 8'h01, {7'h00, osc_ctrl.loco_run});
		wr(AD, 8'h00);
		wr(A1, 8'h38);
		rd(A1, 8'h38, "ls stop set");
		check("loco off", 8'h00, {7'h00, osc_ctrl.loco_run});
		wr(A0, 8'h10);
		cyc(4);
		wr(A0, 8'h90);
		check("src sub", {6'h00, scpc_pkg::SRC_SUB}, {6'h00, sys_clk_src});
		check("sub run", 8'h01, {7'h00, osc_ctrl.sub_run});
		wr(A0, 8'h18);
		wr(A1, 8'h28);
	endtask : t_loco

	task automatic t_wait();
		logic [7:0] c;
		logic [7:0] f;
		wr(A0, 8'h5c);
		wr(A1, 8'he8);
		wr(A3, 8'h21);
		check("wait mode", 8'h02, {5'h00, power_mode});
		count_en(8, c, f);
		check("cpu in wait", 8'h00, c);
		check("f1 stopped", 8'h00, f);
		check("main kept", 8'h01, {7'h00, osc_ctrl.main_run});
		pulse_irq();
		check("woken", 8'h01, {5'h00, power_mode});
		rd(A3, 8'h20, "wait cleared");
		rd(A0, 8'h1c, "coarse cleared");
		rd(A1, 8'h28, "fine cleared");
		wr(A0, 8'h18);
		wr(A3, 8'h01);
		count_en(8, c, f);
		check("f1 running", 8'h08, f);
		pulse_irq();
		rd(A3, 8'h00, "wait cleared 2");
	endtask : t_wait

	task automatic t_stop();
		logic [7:0] c;
		logic [7:0] f;
		wr(AD, 8'h04);
		wr(A0, 8'h38);
		check("main off", 8'h00, {7'h00, osc_ctrl.main_run});
		wr(A3, 8'hc0);
		wr(A1, 8'h29);
		check("stop mode", 8'h04, {5'h00, power_mode});
		check("fb off", 8'h03, {6'h00, osc_ctrl.main_fb_off, osc_ctrl.sub_fb_off});
		count_en(8, c, f);
		check("cpu in stop", 8'h00, c);
		pulse_irq();
		check("run again", 8'h01, {5'h00, power_mode});
		rd(A0, 8'h58, "exit ctrl0");
		rd(AD, 8'h00, "exit sel");
		check("src main", {6'h00, scpc_pkg::SRC_MAIN}, {6'h00, sys_clk_src});
		rd(A1, 8'h28, "ctrl1 run");
	endtask : t_stop

	task automatic t_detect();
		@(posedge clk);
		main_osc_halt_raw <= 1'b1;
		cyc(6);
		rd(AD, 8'h00, "mon off");
		wr(AD, 8'h03);
		cyc(6);
		rd(AD, 8'h0f, "fallback");
		check("irq", 8'h01, {7'h00, osc_stop_irq});
		check("src loco", {6'h00, scpc_pkg::SRC_LOCO}, {6'h00, sys_clk_src});
		wr(AD, 8'h01);
		rd(AD, 8'h0d, "sel kept");
		check("irq off", 8'h00, {7'h00, osc_stop_irq});
		@(posedge clk);
		main_osc_halt_raw <= 1'b0;
		cyc(6);
		rd(AD, 8'h05, "mon clear");
		wr(AD, 8'h00);
		rd(AD, 8'h00, "sel main");
	endtask : t_detect

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		sfr_req = '0;
		protect_bit_0 = 1'b1;
		protect_bit_3 = 1'b0;
		main_osc_halt_raw = 1'b0;
		periph_irq = 1'b0;
		num_errors = 0;
		n_tests = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_protect();
		t_pins();
		t_divide();
		t_prescaler();
		t_loco();
		t_wait();
		t_stop();
		t_detect();
		print_verdict();
	end
endmodule : test_system_clock_power_control
